// ---- verilog/pfd_divider_ctrl.sv ----
// PLL fractional feedback divider control: register map and applied settings
//
// Function
// - Fraction field is a numerator over a fixed denominator of 2^27.
// - Fraction value reaches the PLL only when its top byte is written.
// - Integer divider is ten bits in a 16-bit register, reset 0x6C.
// - Integer value reaches the PLL only when its upper byte is written.
// - Two-bit modulator order: integer, first, second, third; resets to third.
// - Bit 5 adds dither to the modulator; reset leaves it off.
// - Bit 4 noise-shapes the dither; clear leaves it unshaped.
// - Two-bit gain scales dither to one, two, four or eight LSBs.
// - Bit 1 picks reference: 0 crystal input, 1 external clock; reset crystal.
// - Bit 0 enables the reference doubler; enabled after reset.
`timescale 1ns/1ns
module pfd_divider_ctrl (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  output logic [pfd_pkg::PFD_FRAC_BITS-1:0] fractionNumerator,
  output logic [pfd_pkg::PFD_INT_BITS-1:0] integerDivider,
  output pfd_pkg::pfd_order_t modulatorOrder,
  output logic ditherEnable,
  output logic ditherNoiseShaping,
  output logic [3:0] ditherAmplitude,
  output logic referenceSelect,
  output logic doublerEnable
);
  import pfd_pkg::*;

  logic fracWr;
  logic intWr;
  logic sdmWr;
  logic refWr;
  logic [1:0] fracLane;
  logic [1:0] intLane;
  logic [31:0] fracStaged;
  logic [31:0] fracApplied;
  logic [15:0] intStaged;
  logic [15:0] intApplied;
  logic [7:0] sdmReg;
  logic [7:0] refReg;
  logic [7:0] next_rdData;
  logic [31:0] fracView;
  logic [15:0] intView;

  // Write decode; lane index is the offset within each divider register
  always_comb begin
    fracWr = 1'b0;
    intWr = 1'b0;
    sdmWr = 1'b0;
    refWr = 1'b0;
    if (regWrite && regAddr >= PFD_ADDR_FRAC0 && regAddr <= PFD_ADDR_FRAC3) begin
      fracWr = 1'b1;
    end else if (regWrite && (regAddr == PFD_ADDR_INT0 || regAddr == PFD_ADDR_INT1)) begin
      intWr = 1'b1;
    end else if (regWrite && regAddr == PFD_ADDR_SDM) begin
      sdmWr = 1'b1;
    end else if (regWrite && regAddr == PFD_ADDR_REF) begin
      refWr = 1'b1;
    end
  end

  assign fracLane = 2'(regAddr - PFD_ADDR_FRAC0);
  assign intLane = 2'(regAddr - PFD_ADDR_INT0);

  // Fraction numerator, committed on the top byte
  pfd_atomic_reg #(
    .NBYTES(PFD_FRAC_BYTES),
    .RESET_VAL(PFD_FRAC_RESET)
  ) u_frac (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wrEn(fracWr),
    .wrLane(fracLane),
    .wrData(regWrData),
    .staged(fracStaged),
    .applied(fracApplied)
  );

  // Integer divider, committed on the upper byte
  pfd_atomic_reg #(
    .NBYTES(PFD_INT_BYTES),
    .RESET_VAL(PFD_INT_RESET)
  ) u_int (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wrEn(intWr),
    .wrLane(intLane),
    .wrData(regWrData),
    .staged(intStaged),
    .applied(intApplied)
  );

  // Modulator configuration byte, reserved bits dropped on write
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sdmReg <= PFD_SDM_RESET;
    end else if (sdmWr) begin
      sdmReg <= regWrData & PFD_SDM_MASK;
    end
  end

  // Reference configuration byte
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      refReg <= PFD_REF_RESET;
    end else if (refWr) begin
      refReg <= regWrData & PFD_REF_MASK;
    end
  end

  // Settings driven to the analog side, one flop stage after the registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fractionNumerator <= PFD_FRAC_RESET[PFD_FRAC_BITS-1:0];
      integerDivider <= PFD_INT_RESET[PFD_INT_BITS-1:0];
    end else begin
      fractionNumerator <= fracApplied[PFD_FRAC_BITS-1:0];
      integerDivider <= intApplied[PFD_INT_BITS-1:0];
    end
  end

  // Modulator controls; amplitude is one-hot so gain n gives 2^n LSBs
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      modulatorOrder <= pfd_order_t'(PFD_SDM_RESET[PFD_SDM_ORDER_LSB +: 2]);
      ditherEnable <= PFD_SDM_RESET[PFD_SDM_DITHER_EN_BIT];
      ditherNoiseShaping <= PFD_SDM_RESET[PFD_SDM_DITHER_NS_BIT];
      ditherAmplitude <= 4'h1 << PFD_SDM_RESET[PFD_SDM_GAIN_LSB +: 2];
    end else begin
      modulatorOrder <= pfd_order_t'(sdmReg[PFD_SDM_ORDER_LSB +: 2]);
      ditherEnable <= sdmReg[PFD_SDM_DITHER_EN_BIT];
      ditherNoiseShaping <= sdmReg[PFD_SDM_DITHER_NS_BIT];
      ditherAmplitude <= 4'h1 << sdmReg[PFD_SDM_GAIN_LSB +: 2];
    end
  end

  // Reference path controls
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      referenceSelect <= PFD_REF_RESET[PFD_REF_SEL_BIT];
      doublerEnable <= PFD_REF_RESET[PFD_REF_DOUBLER_BIT];
    end else begin
      referenceSelect <= refReg[PFD_REF_SEL_BIT];
      doublerEnable <= refReg[PFD_REF_DOUBLER_BIT];
    end
  end

  // Readback shows staged bytes so software can verify before committing
  assign fracView = fracStaged & PFD_FRAC_MASK;
  assign intView = intStaged & PFD_INT_MASK;

  // Read decode; unmapped offsets return zero
  always_comb begin
    next_rdData = 8'h00;
    if (regAddr >= PFD_ADDR_FRAC0 && regAddr <= PFD_ADDR_FRAC3) begin
      next_rdData = fracView[8*fracLane +: 8];
    end else if (regAddr == PFD_ADDR_INT0 || regAddr == PFD_ADDR_INT1) begin
      next_rdData = intView[8*intLane +: 8];
    end else if (regAddr == PFD_ADDR_SDM) begin
      next_rdData = sdmReg;
    end else if (regAddr == PFD_ADDR_REF) begin
      next_rdData = refReg;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdData <= next_rdData;
      end
    end
  end

  // Checks on committed settings and register readback
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_frac_commit_top: assert property (
    fracWr && fracLane == 2'h3 |-> ##2 fractionNumerator == {$past(regWrData[2:0], 2), $past(fracStaged[23:0], 2)})
    else $error("fraction not applied after top byte write");

  a_frac_low_hold: assert property (
    fracWr && fracLane != 2'h3 && !intWr |=> fracApplied == $past(fracApplied))
    else $error("fraction applied changed on low byte write");

  a_frac_width: assert property (
    fracWr && fracLane == 2'h3 |-> ##2 fractionNumerator == $past(fracApplied[26:0]) && fracView[31:27] == 5'h00)
    else $error("fraction numerator wider than 27 bits");

  a_int_commit_top: assert property (
    intWr && intLane == 2'h1 |-> ##2 integerDivider == {$past(regWrData[1:0], 2), $past(intStaged[7:0], 2)})
    else $error("integer not applied after upper byte write");

  a_int_low_hold: assert property (
    intWr && intLane == 2'h0 |-> ##2 integerDivider == $past(integerDivider))
    else $error("integer changed on low byte write");

  a_int_reset_val: assert property (
    $rose(reset_n) && !intWr |-> integerDivider == PFD_INT_RESET[PFD_INT_BITS-1:0])
    else $error("integer divider reset value wrong");

  a_order_follow: assert property (
    sdmWr |-> ##2 modulatorOrder == pfd_order_t'($past(regWrData[1:0], 2)))
    else $error("modulator order does not follow write");

  a_dither_bits: assert property (
    sdmWr |-> ##2 ditherEnable == $past(regWrData[5], 2) && ditherNoiseShaping == $past(regWrData[4], 2))
    else $error("dither enable or shaping wrong");

  a_dither_gain: assert property (
    sdmWr |-> ##2 ditherAmplitude == (4'h1 << $past(regWrData[3:2], 2)))
    else $error("dither amplitude does not match gain");

  a_ref_select: assert property (
    refWr |-> ##2 referenceSelect == $past(regWrData[1], 2) && doublerEnable == $past(regWrData[0], 2))
    else $error("reference select or doubler wrong");

  a_read_answer: assert property (
    regRead |=> regRdValid && regRdData == $past(next_rdData))
    else $error("read answer missing or wrong");

  // Main scenarios
  c_frac_commit: cover property (fracWr && fracLane == 2'h2 ##[1:8] fracWr && fracLane == 2'h3);
  c_int_commit: cover property (intWr && intLane == 2'h0 ##[1:8] intWr && intLane == 2'h1);
  c_dither_max: cover property (ditherEnable && ditherAmplitude == 4'h8);
  c_ext_ref: cover property (referenceSelect && !doublerEnable);

endmodule : pfd_divider_ctrl

// ---- verilog/pfd_pkg.sv ----
// Constants for the PLL feedback divider control block
package pfd_pkg;

  // Byte offsets within the divider control register map
  localparam logic [7:0] PFD_ADDR_FRAC0 = 8'h00;
  localparam logic [7:0] PFD_ADDR_FRAC3 = 8'h03;
  localparam logic [7:0] PFD_ADDR_INT0 = 8'h04;
  localparam logic [7:0] PFD_ADDR_INT1 = 8'h05;
  localparam logic [7:0] PFD_ADDR_SDM = 8'h06;
  localparam logic [7:0] PFD_ADDR_REF = 8'h07;

  // Register widths in bytes
  localparam int PFD_FRAC_BYTES = 4;
  localparam int PFD_INT_BYTES = 2;

  // Field widths; the fraction denominator is two to this power
  localparam int PFD_FRAC_BITS = 27;
  localparam int PFD_INT_BITS = 10;

  // Values after reset
  localparam logic [31:0] PFD_FRAC_RESET = 32'h0000_0000;
  localparam logic [15:0] PFD_INT_RESET = 16'h006c;
  localparam logic [7:0] PFD_SDM_RESET = 8'h03;
  localparam logic [7:0] PFD_REF_RESET = 8'h01;

  // Readable bit masks, reserved bits read zero
  localparam logic [31:0] PFD_FRAC_MASK = 32'h07ff_ffff;
  localparam logic [15:0] PFD_INT_MASK = 16'h03ff;
  localparam logic [7:0] PFD_SDM_MASK = 8'h3f;
  localparam logic [7:0] PFD_REF_MASK = 8'h03;

  // Field positions in the modulator byte
  localparam int PFD_SDM_DITHER_EN_BIT = 5;
  localparam int PFD_SDM_DITHER_NS_BIT = 4;
  localparam int PFD_SDM_GAIN_LSB = 2;
  localparam int PFD_SDM_ORDER_LSB = 0;

  // Field positions in the reference byte
  localparam int PFD_REF_SEL_BIT = 1;
  localparam int PFD_REF_DOUBLER_BIT = 0;

  // Modulator order encodings
  typedef enum logic [1:0] {
    PFD_ORDER_INTEGER = 2'h0,
    PFD_ORDER_FIRST = 2'h1,
    PFD_ORDER_SECOND = 2'h2,
    PFD_ORDER_THIRD = 2'h3
  } pfd_order_t;

endpackage : pfd_pkg

// ---- verilog/pfd_atomic_reg.sv ----
// Byte-staged register that commits to its applied copy on a top-byte write
`timescale 1ns/1ns
module pfd_atomic_reg #(
  parameter int NBYTES = 4,
  parameter logic [8*NBYTES-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wrEn,
  input wire logic [1:0] wrLane,
  input wire logic [7:0] wrData,
  output logic [8*NBYTES-1:0] staged,
  output logic [8*NBYTES-1:0] applied
);

  logic commit;

  // Only the most significant byte lane triggers the commit
  assign commit = wrEn && (32'(wrLane) == NBYTES - 1);

  // Staging copy, what software last wrote per lane
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      staged <= RESET_VAL;
    end else if (wrEn) begin
      staged[8*wrLane +: 8] <= wrData;
    end
  end

  // Applied copy, changes as a whole so the PLL never sees a torn value
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      applied <= RESET_VAL;
    end else if (commit) begin
      applied <= {wrData, staged[8*NBYTES-9:0]};
    end
  end

endmodule : pfd_atomic_reg

// ---- verif/tb_pll_feedback_divider_control.sv ----
// Self-checking bench for the PLL feedback divider control block
`timescale 1ns/1ns
module tb_pll_feedback_divider_control;
  import pfd_pkg::*;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic regRdValid;
  logic [PFD_FRAC_BITS-1:0] fractionNumerator;
  logic [PFD_INT_BITS-1:0] integerDivider;
  pfd_order_t modulatorOrder;
  logic ditherEnable;
  logic ditherNoiseShaping;
  logic [3:0] ditherAmplitude;
  logic referenceSelect;
  logic doublerEnable;
  int miscompares = 0;
  int check_count = 0;

  pfd_divider_ctrl i_pfd_divider_ctrl (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .regWrite(regWrite),
    .regRead(regRead),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .regRdValid(regRdValid),
    .fractionNumerator(fractionNumerator),
    .integerDivider(integerDivider),
    .modulatorOrder(modulatorOrder),
    .ditherEnable(ditherEnable),
    .ditherNoiseShaping(ditherNoiseShaping),
    .ditherAmplitude(ditherAmplitude),
    .referenceSelect(referenceSelect),
    .doublerEnable(doublerEnable)
  );

  // 100 MHz system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Compare and count; four-state equality so unknowns never match
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One byte write; waits an edge first so strobes never toggle twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    regWrite = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge clk_sys);
    #1;
    regWrite = 1'b0;
  endtask : wr

  // One byte read; answer stands exactly one cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge clk_sys);
    #1;
    regRead = 1'b0;
    chk("read valid", {31'h0, regRdValid}, 32'h1);
    chk("read data", {24'h0, regRdData}, {24'h0, exp});
  endtask : rd

  // Settings outputs land two edges after the committing write
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    logic [7:0] d;
    repeat (3) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    chk("frac", 32'(fractionNumerator), 32'h0);
    chk("int", 32'(integerDivider), 32'h6c);
    chk("order", 32'(modulatorOrder), 32'h3);
    chk("dither en", 32'(ditherEnable), 32'h0);
    chk("dither ns", 32'(ditherNoiseShaping), 32'h0);
    chk("amplitude", 32'(ditherAmplitude), 32'h1);
    chk("ref sel", 32'(referenceSelect), 32'h0);
    chk("doubler", 32'(doublerEnable), 32'h1);
    rd(PFD_ADDR_INT0, 8'h6c);
    rd(PFD_ADDR_INT1, 8'h00);
    rd(PFD_ADDR_SDM, 8'h03);
    rd(PFD_ADDR_REF, 8'h01);
    $display("test reset done");
    // Lower fraction bytes stay staged; top byte with reserved bits set commits
    wr(PFD_ADDR_FRAC0, 8'h67);
    wr(8'h01, 8'h45);
    wr(8'h02, 8'h23);
    settle();
    chk("frac staged", 32'(fractionNumerator), 32'h0);
    rd(8'h01, 8'h45);
    wr(PFD_ADDR_FRAC3, 8'hf1);
    settle();
    chk("frac commit", 32'(fractionNumerator), 32'h1234567);
    rd(PFD_ADDR_FRAC3, 8'h01);
    wr(PFD_ADDR_FRAC3, 8'h04);
    settle();
    chk("frac top only", 32'(fractionNumerator), 32'h4234567);
    $display("test fraction done");
    // Integer divider: low byte staged, high byte commits ten bits
    wr(PFD_ADDR_INT0, 8'ha5);
    settle();
    chk("int staged", 32'(integerDivider), 32'h6c);
    wr(PFD_ADDR_INT1, 8'hff);
    settle();
    chk("int commit", 32'(integerDivider), 32'h3a5);
    rd(PFD_ADDR_INT1, 8'h03);
    $display("test integer done");
    // Every order and gain code, with dither bits varied and reserved bits set
    for (int i = 0; i < 16; i++) begin
      d = {2'b11, ~i[0], i[1] ^ i[2], i[3:2], i[1:0]};
      wr(PFD_ADDR_SDM, d);
      settle();
      chk("order", 32'(modulatorOrder), 32'(d[1:0]));
      chk("dither en", 32'(ditherEnable), 32'(d[5]));
      chk("dither ns", 32'(ditherNoiseShaping), 32'(d[4]));
      chk("amplitude", 32'(ditherAmplitude), 32'(4'h1 << d[3:2]));
      rd(PFD_ADDR_SDM, d & 8'h3f);
    end
    $display("test modulator done");
    // Reference select and doubler, all four combinations
    for (int i = 0; i < 4; i++) begin
      d = {6'h3f, i[1:0]};
      wr(PFD_ADDR_REF, d);
      settle();
      chk("ref sel", 32'(referenceSelect), 32'(d[1]));
      chk("doubler", 32'(doublerEnable), 32'(d[0]));
      rd(PFD_ADDR_REF, d & 8'h03);
    end
    $display("test reference done");
    // Unmapped offset: write ignored, read returns zero
    wr(8'h08, 8'h00);
    settle();
    rd(8'h08, 8'h00);
    chk("ref kept", 32'(referenceSelect), 32'h1);
    chk("doubler kept", 32'(doublerEnable), 32'h1);
    $display("test unmapped done");
    // Reset in mid-run brings every changed setting back to its reset value
    @(posedge clk_sys);
    #1;
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    chk("frac reset", 32'(fractionNumerator), 32'h0);
    chk("int reset", 32'(integerDivider), 32'h6c);
    chk("order reset", 32'(modulatorOrder), 32'h3);
    chk("amplitude reset", 32'(ditherAmplitude), 32'h1);
    chk("ref sel reset", 32'(referenceSelect), 32'h0);
    chk("doubler reset", 32'(doublerEnable), 32'h1);
    rd(PFD_ADDR_FRAC0, 8'h00);
    rd(PFD_ADDR_INT0, 8'h6c);
    $display("test mid reset done");
    wrap_up();
  end

  // Hang guard: a bounded wait that counts as a mismatch when used up
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    $display("Error timeout expected finish seen hang");
    wrap_up();
  end
endmodule : tb_pll_feedback_divider_control
